// [dmci_map.svh]
`ifndef DMCI_MAP_SVH
`define DMCI_MAP_SVH

// Word offsets in the shared two-port memory (32-bit words)
`define DMCI_W_CMD 6'h00
`define DMCI_W_ARG 6'h01
`define DMCI_W_WRIDX 6'h05
`define DMCI_W_RDIDX 6'h06
`define DMCI_W_RING 6'h10
`define DMCI_RING_LAST 3'h5
`define DMCI_ARG_WORDS 4'h4
`define DMCI_SEG_WORDS 4'h8

// Command word fields
`define DMCI_F_VALID 31
`define DMCI_VALID_MASK 32'h80000000
`define DMCI_F_OP 7:0
`define DMCI_F_AXES 11:8
`define DMCI_F_CUBIC 12
`define DMCI_F_RATE 15:13
`define DMCI_F_IRQ 21:16

// Command codes
`define DMCI_OP_MOVE 8'h01
`define DMCI_OP_STOP 8'h02
`define DMCI_OP_CONTOUR 8'h03
`define DMCI_OP_INTEN 8'h04
`define DMCI_OP_INTACK 8'h05

// Interrupt condition bits
`define DMCI_IRQ_RING_EMPTY 4
`define DMCI_IRQ_RTC_DONE 5

// Timing
`define DMCI_CLK_NS 10
`define DMCI_SAMPLE_NS 200000
`define DMCI_SAMPLE_CYC ((`DMCI_SAMPLE_NS + `DMCI_CLK_NS - 1) / `DMCI_CLK_NS)
`define DMCI_FRAC 16

`endif

// [dmci_pkg.sv]
package dmci_pkg;

   typedef enum logic [8:0] {
      ST_POLL_CMD = 9'h001,
      ST_WAIT_CMD = 9'h002,
      ST_RD_ARG = 9'h004,
      ST_APPLY = 9'h008,
      ST_POLL_RING = 9'h010,
      ST_WAIT_RING = 9'h020,
      ST_RD_SEG = 9'h040,
      ST_LOAD_SEG = 9'h080,
      ST_WR_IDX = 9'h100
   } dmci_fsm_t;

   typedef struct packed {
      logic signed [31:0] pos;
      logic signed [31:0] vel;
   } dmci_axis_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [5:0] addr;
      logic [31:0] wdata;
   } dmci_port_t;

   typedef struct packed {
      logic [63:0][31:0] mem;
      logic [31:0] host_rd;
      logic [31:0] dev_rd;
   } dmci_mem_st_t;

   typedef struct packed {
      logic signed [63:0] acc;
      logic signed [63:0] d1;
      logic signed [63:0] d2;
      logic signed [63:0] d3;
      logic signed [31:0] v;
      dmci_axis_t tgt;
      logic [7:0] cnt;
      logic busy;
      logic done;
   } dmci_interp_st_t;

   typedef struct packed {
      dmci_fsm_t fsm;
      logic [31:0] cmd;
      logic [3:0] cnt;
      logic [3:0][31:0] args;
      logic [7:0][31:0] seg;
      logic [2:0] rd_idx;
      logic contour_on;
      logic cubic;
      logic [2:0] rate;
      logic [3:0] caxes;
      logic [5:0] irq_en;
      logic [5:0] irq_st;
      logic irq;
      logic ack;
      logic [3:0] qa1;
      logic [3:0] qa2;
      logic [3:0] qap;
      logic [3:0] qb1;
      logic [3:0] qb2;
      logic [3:0] qbp;
      logic [3:0][31:0] act;
      logic [3:0][31:0] ferr;
      logic [15:0] tick_cnt;
      logic tick;
   } dmci_st_t;

endpackage : dmci_pkg

// [dmci_mem.sv]
`timescale 1ns/1ns
`include "dmci_map.svh"

module dmci_mem
   import dmci_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Host port
   input dmci_port_t host_p,
   output logic [31:0] host_rdata,
   // Device port
   input dmci_port_t dev_p,
   output logic [31:0] dev_rdata
);

   dmci_mem_st_t s;
   dmci_mem_st_t n;

   // Host write wins a same-word collision so a fresh command is never lost
   always_comb begin
      n = s;
      if (dev_p.en && dev_p.we) begin
         n.mem[dev_p.addr] = dev_p.wdata;
      end
      if (host_p.en && host_p.we) begin
         n.mem[host_p.addr] = host_p.wdata;
      end
      if (host_p.en) begin
         n.host_rd = s.mem[host_p.addr];
      end
      if (dev_p.en) begin
         n.dev_rd = s.mem[dev_p.addr];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign host_rdata = s.host_rd;
   assign dev_rdata = s.dev_rd;

endmodule : dmci_mem

// [dmci_interp.sv]
`timescale 1ns/1ns
`include "dmci_map.svh"

module dmci_interp
   import dmci_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic tick,
   input wire logic seg_go,
   input wire logic preset,
   input wire logic halt,
   input wire logic cubic,
   input wire logic [2:0] rate,
   input dmci_axis_t seg,
   input wire logic [31:0] preset_pos,
   // Status
   output dmci_axis_t axis_o,
   output logic busy,
   output logic done
);

   dmci_interp_st_t s;
   dmci_interp_st_t n;
   logic signed [63:0] dp;
   logic signed [63:0] v0;
   logic signed [63:0] v1;
   logic signed [63:0] a;
   logic signed [63:0] b;
   logic [4:0] sh2;
   logic [4:0] sh3;

   always_comb begin
      n = s;
      n.done = 1'b0;
      sh2 = {1'b0, rate, 1'b0};
      sh3 = 5'({rate, 1'b0}) + 5'(rate);
      dp = {{16{seg.pos[31]}}, seg.pos, 16'h0000} - s.acc;
      v0 = {{32{s.v[31]}}, s.v};
      v1 = {{32{seg.vel[31]}}, seg.vel};
      // Hermite cubic or constant-acceleration blend over 2**rate samples
      if (cubic) begin
         a = (dp + (dp <<< 1) - (((v0 <<< 1) + v1) <<< rate)) >>> sh2;
         b = (((v0 + v1) <<< rate) - (dp <<< 1)) >>> sh3;
      end else begin
         a = (v1 - v0) >>> (4'(rate) + 4'h1);
         b = 64'sh0;
      end
      if (preset || halt) begin
         if (preset) begin
            n.acc = {{16{preset_pos[31]}}, preset_pos, 16'h0000};
         end
         n.v = 32'sh0;
         n.busy = 1'b0;
         n.d1 = 64'sh0;
         n.d2 = 64'sh0;
         n.d3 = 64'sh0;
      end else if (seg_go) begin
         n.d1 = v0 + a + b;
         n.d2 = (a <<< 1) + (b <<< 2) + (b <<< 1);
         n.d3 = (b <<< 2) + (b <<< 1);
         n.cnt = 8'h01 << rate;
         n.tgt = seg;
         n.busy = 1'b1;
      end else if (tick && s.busy) begin
         n.acc = s.acc + s.d1;
         n.v = s.d1[31:0];
         n.d1 = s.d1 + s.d2;
         n.d2 = s.d2 + s.d3;
         n.cnt = s.cnt - 8'h01;
         if (s.cnt == 8'h01) begin
            n.acc = {{16{s.tgt.pos[31]}}, s.tgt.pos, 16'h0000};
            n.v = s.tgt.vel;
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign axis_o.pos = s.acc[47:16];
   assign axis_o.vel = s.v;
   assign busy = s.busy;
   assign done = s.done;

   seg_span_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (seg_go && !preset && !halt) |=> (s.busy && s.cnt == (8'h01 << $past(rate))))
      else $error("segment interval not loaded from rate");

endmodule : dmci_interp

// [dmci_intake.sv]
`timescale 1ns/1ns
`include "dmci_map.svh"

module dmci_intake
   import dmci_pkg::*;
#(
   parameter int unsigned SAMPLE_CYC = `DMCI_SAMPLE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Host bus, synchronous to core_clk
   input wire logic host_sel,
   input wire logic host_we,
   input wire logic [5:0] host_addr,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata,
   output logic host_ack,
   output logic host_irq,
   // Quadrature encoders
   input wire logic [3:0] enc_a,
   input wire logic [3:0] enc_b,
   // Axis state
   output dmci_axis_t [3:0] axis_o,
   output logic [3:0][31:0] ferr_o
);

   dmci_st_t s;
   dmci_st_t n;
   dmci_port_t hp;
   dmci_port_t dp;
   logic [31:0] mem_rd;
   logic [3:0] seg_go;
   logic [3:0] preset;
   logic [3:0] halt;
   logic [3:0] busy;
   logic [3:0] done;
   logic [5:0] ev;
   logic [5:0] clr;
   logic [3:0] cmd_axes;

   // Signed step of one quadrature transition
   function automatic logic [31:0] qd_step(input logic a0, input logic b0,
                                           input logic a1, input logic b1);
      logic [31:0] r;
      r = 32'h00000000;
      if ((a0 ^ a1) ^ (b0 ^ b1)) begin
         r = (a0 ^ b1) ? 32'hFFFFFFFF : 32'h00000001;
      end
      return r;
   endfunction : qd_step

   assign cmd_axes = s.cmd[`DMCI_F_AXES];

   always_comb begin
      hp.en = host_sel;
      hp.we = host_we;
      hp.addr = host_addr;
      hp.wdata = host_wdata;
   end

   dmci_mem u_mem (
      .core_clk(core_clk),
      .rstn(rstn),
      .host_p(hp),
      .host_rdata(host_rdata),
      .dev_p(dp),
      .dev_rdata(mem_rd)
   );

   for (genvar i = 0; i < 4; i++) begin : g_ax
      dmci_axis_t seg_i;
      assign seg_i.pos = s.seg[2 * i];
      assign seg_i.vel = s.seg[2 * i + 1];
      dmci_interp u_interp (
         .core_clk(core_clk),
         .rstn(rstn),
         .tick(s.tick),
         .seg_go(seg_go[i]),
         .preset(preset[i]),
         .halt(halt[i]),
         .cubic(s.cubic),
         .rate(s.rate),
         .seg(seg_i),
         .preset_pos(s.args[i]),
         .axis_o(axis_o[i]),
         .busy(busy[i]),
         .done(done[i])
      );

      multi_axis_a: assert property (@(posedge core_clk) disable iff (!rstn)
         (s.fsm == ST_APPLY && s.cmd[`DMCI_F_OP] == `DMCI_OP_MOVE && cmd_axes[i])
         |=> axis_o[i].pos == $past(s.args[i]))
         else $error("axis missed a multi-axis move");
   end

   always_comb begin
      n = s;
      dp = '0;
      seg_go = 4'h0;
      preset = 4'h0;
      halt = 4'h0;
      clr = 6'h00;
      ev = {2'b00, done};
      n.ack = host_sel;
      n.tick = 1'b0;
      if (s.tick_cnt == 16'h0000) begin
         n.tick_cnt = 16'(SAMPLE_CYC - 1);
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = s.tick_cnt - 16'h0001;
      end
      n.qa1 = enc_a;
      n.qa2 = s.qa1;
      n.qap = s.qa2;
      n.qb1 = enc_b;
      n.qb2 = s.qb1;
      n.qbp = s.qb2;
      for (int i = 0; i < 4; i++) begin
         n.act[i] = s.act[i] + qd_step(s.qap[i], s.qbp[i], s.qa2[i], s.qb2[i]);
         n.ferr[i] = axis_o[i].pos - s.act[i];
      end
      case (s.fsm)
         ST_POLL_CMD: begin
            dp.en = 1'b1;
            dp.addr = `DMCI_W_CMD;
            n.fsm = ST_WAIT_CMD;
         end
         ST_WAIT_CMD: begin
            if (mem_rd[`DMCI_F_VALID]) begin
               n.cmd = mem_rd;
               n.cnt = 4'h0;
               n.fsm = ST_RD_ARG;
            end else begin
               n.fsm = ST_POLL_RING;
            end
         end
         ST_RD_ARG: begin
            if (s.cnt < `DMCI_ARG_WORDS) begin
               dp.en = 1'b1;
               dp.addr = `DMCI_W_ARG + 6'(s.cnt);
            end
            if (s.cnt != 4'h0) begin
               n.args[s.cnt[1:0] - 2'h1] = mem_rd;
            end
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == `DMCI_ARG_WORDS) begin
               n.fsm = ST_APPLY;
            end
         end
         ST_APPLY: begin
            // Clearing the valid bit hands the window back to the host
            dp.en = 1'b1;
            dp.we = 1'b1;
            dp.addr = `DMCI_W_CMD;
            dp.wdata = s.cmd & ~`DMCI_VALID_MASK;
            case (s.cmd[`DMCI_F_OP])
               `DMCI_OP_MOVE: begin
                  preset = cmd_axes;
               end
               `DMCI_OP_STOP: begin
                  halt = cmd_axes;
                  n.contour_on = 1'b0;
               end
               `DMCI_OP_CONTOUR: begin
                  n.contour_on = 1'b1;
                  n.cubic = s.cmd[`DMCI_F_CUBIC];
                  n.rate = s.cmd[`DMCI_F_RATE];
                  n.caxes = cmd_axes;
               end
               `DMCI_OP_INTEN: begin
                  n.irq_en = s.cmd[`DMCI_F_IRQ];
               end
               `DMCI_OP_INTACK: begin
                  clr = s.cmd[`DMCI_F_IRQ];
               end
               default: begin
               end
            endcase
            ev[`DMCI_IRQ_RTC_DONE] = 1'b1;
            n.fsm = ST_POLL_RING;
         end
         ST_POLL_RING: begin
            if (s.contour_on && (busy & s.caxes) == 4'h0) begin
               dp.en = 1'b1;
               dp.addr = `DMCI_W_WRIDX;
               n.fsm = ST_WAIT_RING;
            end else begin
               n.fsm = ST_POLL_CMD;
            end
         end
         ST_WAIT_RING: begin
            if (mem_rd[2:0] != s.rd_idx) begin
               n.cnt = 4'h0;
               n.fsm = ST_RD_SEG;
            end else begin
               ev[`DMCI_IRQ_RING_EMPTY] = 1'b1;
               n.fsm = ST_POLL_CMD;
            end
         end
         ST_RD_SEG: begin
            if (s.cnt < `DMCI_SEG_WORDS) begin
               dp.en = 1'b1;
               dp.addr = `DMCI_W_RING + {s.rd_idx, s.cnt[2:0]};
            end
            if (s.cnt != 4'h0) begin
               n.seg[s.cnt[2:0] - 3'h1] = mem_rd;
            end
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == `DMCI_SEG_WORDS) begin
               n.fsm = ST_LOAD_SEG;
            end
         end
         ST_LOAD_SEG: begin
            seg_go = s.caxes;
            n.rd_idx = (s.rd_idx == `DMCI_RING_LAST) ? 3'h0 : s.rd_idx + 3'h1;
            n.fsm = ST_WR_IDX;
         end
         ST_WR_IDX: begin
            dp.en = 1'b1;
            dp.we = 1'b1;
            dp.addr = `DMCI_W_RDIDX;
            dp.wdata = {29'h00000000, s.rd_idx};
            n.fsm = ST_POLL_CMD;
         end
         default: begin
            n.fsm = ST_POLL_CMD;
         end
      endcase
      // A new event wins over a clear in the same cycle
      n.irq_st = (s.irq_st & ~clr) | ev;
      n.irq = |(n.irq_st & n.irq_en);
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
         s.fsm <= ST_POLL_CMD;
      end else begin
         s <= n;
      end
   end

   assign host_ack = s.ack;
   assign host_irq = s.irq;
   assign ferr_o = s.ferr;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   poll_window_a: assert property (s.fsm == ST_WAIT_CMD |->
      ($past(dp.en) && $past(dp.addr) == `DMCI_W_CMD && !$past(dp.we)))
      else $error("command window not polled");

   rtc_latency_a: assert property ((s.fsm == ST_WAIT_CMD && mem_rd[31]) |->
      ##6 s.fsm == ST_APPLY)
      else $error("command not executed promptly");

   stop_override_a: assert property ((s.fsm == ST_APPLY
      && s.cmd[`DMCI_F_OP] == `DMCI_OP_STOP) |=> ((busy & $past(cmd_axes)) == 4'h0))
      else $error("stop did not override motion");

   seg_order_a: assert property ((|seg_go) |-> ((busy & s.caxes) == 4'h0))
      else $error("segment started over a busy axis");

   index_gate_a: assert property ((s.fsm == ST_WAIT_RING
      && mem_rd[2:0] == s.rd_idx) |=> s.fsm == ST_POLL_CMD)
      else $error("segment read past write index");

   ring_wrap_a: assert property (s.fsm == ST_LOAD_SEG |=>
      s.rd_idx == (($past(s.rd_idx) == 3'h5) ? 3'h0 : $past(s.rd_idx) + 3'h1))
      else $error("ring read index stepped wrongly");

   quad_edge_a: assert property (((s.qa2[0] ^ s.qap[0]) ^ (s.qb2[0] ^ s.qbp[0]))
      |=> (s.act[0] != $past(s.act[0])))
      else $error("encoder edge not counted");

   host_ack_a: assert property (host_sel |=> host_ack)
      else $error("host access not acknowledged");

   irq_gate_a: assert property (host_irq |-> ((s.irq_st & s.irq_en) != 6'h00))
      else $error("interrupt raised while masked");

   sample_tick_a: assert property (s.tick |=> (!s.tick) [*2])
      else $error("sample tick too frequent");

   rtc_cov: cover property (s.fsm == ST_APPLY);
   seg_cov: cover property (s.fsm == ST_LOAD_SEG ##[1:300] s.fsm == ST_APPLY);
   irq_cov: cover property ($rose(host_irq));

endmodule : dmci_intake

// [dmci_host_model.sv]
`timescale 1ns/1ns
`include "dmci_map.svh"

module dmci_host_model
   import dmci_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Host bus requests
   output logic host_sel,
   output logic host_we,
   output logic [5:0] host_addr,
   output logic [31:0] host_wdata,
   // Host bus answers
   input wire logic [31:0] host_rdata,
   input wire logic host_ack
);
   logic slow = 1'b0;
   logic [2:0] wr_idx = 3'h0;
   int n_noack = 0;

   initial begin
      host_sel = 1'b0;
      host_we = 1'b0;
      host_addr = 6'h00;
      host_wdata = 32'h0;
   end

   // One word access like any plain peripheral; answer taken one cycle after the request
   task automatic access(input logic we, input logic [5:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic ok);
      repeat (slow ? $urandom_range(0, 3) : 0) @(negedge core_clk);
      @(negedge core_clk);
      host_sel = 1'b1;
      host_we = we;
      host_addr = a;
      host_wdata = d;
      @(negedge core_clk);
      ok = (host_ack === 1'b1);
      q = host_rdata;
      host_sel = 1'b0;
      host_we = 1'b0;
      // Released lines carry no stale value
      host_addr = ~a;
      host_wdata = ~d;
   endtask : access

   // Whole entry into the next ring slot, position then velocity per axis
   task automatic put_seg(input logic [7:0][31:0] w);
      logic [31:0] q;
      logic ok;
      for (int i = 0; i < 8; i++) begin
         access(1'b1, `DMCI_W_RING + 6'(wr_idx) * 6'h08 + 6'(i), w[i], q, ok);
         if (!ok) n_noack++;
      end
      wr_idx = (wr_idx == `DMCI_RING_LAST) ? 3'h0 : wr_idx + 3'h1;
   endtask : put_seg

   // Write index moves only past complete entries
   task automatic publish();
      logic [31:0] q;
      logic ok;
      access(1'b1, `DMCI_W_WRIDX, {29'h0, wr_idx}, q, ok);
      if (!ok) n_noack++;
   endtask : publish
endmodule : dmci_host_model

// [dmci_intake_tb.sv]
`timescale 1ns/1ns
`include "dmci_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module dmci_intake_tb
   import dmci_pkg::*;
;
   localparam int SCYC = 40;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic host_sel, host_we, host_ack, host_irq;
   logic [5:0] host_addr;
   logic [31:0] host_wdata, host_rdata;
   logic [3:0] enc_a = 4'h0;
   logic [3:0] enc_b = 4'h0;
   dmci_axis_t [3:0] axis_o;
   logic [3:0][31:0] ferr_o;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] mem_m [64];
   logic [31:0] last_pos [4];
   time chg_t [4];

   always #5 core_clk = ~core_clk;

   dmci_intake #(.SAMPLE_CYC(SCYC)) u_dut (.core_clk(core_clk), .rstn(rstn),
      .host_sel(host_sel), .host_we(host_we), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
      .host_irq(host_irq), .enc_a(enc_a), .enc_b(enc_b), .axis_o(axis_o), .ferr_o(ferr_o));

   dmci_host_model u_host (.core_clk(core_clk), .host_sel(host_sel), .host_we(host_we),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_ack(host_ack));

   // Time of the last position change per axis
   always @(negedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (axis_o[i].pos !== last_pos[i]) chg_t[i] = $time;
         last_pos[i] = axis_o[i].pos;
      end
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 50000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic hw(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic ok;
      u_host.access(1'b1, a, d, q, ok);
      mem_m[a] = d;
      `CHK(ok, 1'b1)
   endtask : hw

   task automatic hr(input logic [5:0] a, output logic [31:0] q);
      logic ok;
      u_host.access(1'b0, a, 32'h0, q, ok);
      `CHK(ok, 1'b1)
   endtask : hr

   // Command word, then poll until the valid bit is cleared
   task automatic cmd(input logic [7:0] op, input logic [3:0] ax, input logic cub,
                      input logic [2:0] rate, input logic [5:0] irq);
      logic [31:0] w;
      logic [31:0] q;
      w = `DMCI_VALID_MASK | {10'h0, irq, rate, cub, ax, op};
      hw(`DMCI_W_CMD, w);
      for (int n = 0; n < 100; n++) begin
         hr(`DMCI_W_CMD, q);
         if (q[`DMCI_F_VALID] === 1'b0) break;
      end
      mem_m[0] = w & ~`DMCI_VALID_MASK;
      `CHK(q, mem_m[0])
      repeat (3) @(negedge core_clk);
   endtask : cmd

   task automatic wait_rd(input logic [2:0] v);
      logic [31:0] q;
      for (int n = 0; n < 600; n++) begin
         hr(`DMCI_W_RDIDX, q);
         if (q === {29'h0, v}) break;
      end
      `CHK(q, {29'h0, v})
   endtask : wait_rd

   task automatic seg(input logic [31:0] t);
      logic [7:0][31:0] w;
      w = '0;
      w[0] = t;
      w[1] = 32'h0001_0000;
      u_host.put_seg(w);
   endtask : seg

   initial begin
      logic [31:0] q;
      logic [31:0] a [4];
      logic [31:0] old [4];
      logic [31:0] tg [4];
      logic [3:0] mk;
      logic [1:0] ph [4];
      logic [31:0] f0;
      int d;
      void'($urandom(15));
      ph = '{2'b00, 2'b10, 2'b11, 2'b01};
      for (int i = 0; i < 64; i++) mem_m[i] = 32'h0;
      repeat (10) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      `CHK({host_ack, host_irq, axis_o, ferr_o}, '0)
      for (int i = 0; i < 64; i++) begin
         hr(6'(i), q);
         `CHK(q, mem_m[i])
      end
      $display("reset test done");
      u_host.slow = 1'b1;
      for (int i = 0; i < 24; i++) hw(6'h10 + 6'($urandom_range(0, 47)), $urandom);
      for (int i = 1; i < 64; i++) begin
         if (i < 5 || i >= 16) begin
            hr(6'(i), q);
            `CHK(q, mem_m[i])
         end
      end
      u_host.slow = 1'b0;
      $display("memory test done");
      for (int r = 0; r < 3; r++) begin
         mk = (r == 2) ? 4'hF : 4'($urandom_range(1, 14));
         for (int i = 0; i < 4; i++) begin
            a[i] = $urandom;
            old[i] = axis_o[i].pos;
            hw(6'(1 + i), a[i]);
         end
         cmd(`DMCI_OP_MOVE, mk, 1'b0, 3'h0, 6'h00);
         for (int i = 0; i < 4; i++) begin
            `CHK(axis_o[i].pos, mk[i] ? a[i] : old[i])
            if (mk[i] && mk[3]) `CHK(chg_t[i], chg_t[3])
         end
      end
      $display("move test done");
      f0 = ferr_o[0];
      for (int i = 1; i <= 4; i++) begin
         {enc_a[0], enc_b[0]} = ph[i % 4];
         repeat (4) @(negedge core_clk);
      end
      repeat (6) @(negedge core_clk);
      d = int'(f0) - int'(ferr_o[0]);
      `CHK(d == 4 || d == -4, 1'b1)
      for (int i = 3; i >= 0; i--) begin
         {enc_a[0], enc_b[0]} = ph[i];
         repeat (4) @(negedge core_clk);
      end
      repeat (6) @(negedge core_clk);
      `CHK(ferr_o[0], f0)
      $display("encoder test done");
      for (int i = 0; i < 4; i++) tg[i] = a[0] + 32'($urandom_range(0, 8191)) - 32'h1000;
      cmd(`DMCI_OP_CONTOUR, 4'h1, 1'b0, 3'h1, 6'h00);
      for (int e = 0; e < 3; e++) seg(tg[e]);
      u_host.publish();
      wait_rd(3'h2);
      `CHK(axis_o[0].pos, tg[0])
      wait_rd(3'h3);
      `CHK(axis_o[0].pos, tg[1])
      for (int n = 0; n < 3000 && axis_o[0] !== {tg[2], 32'h0001_0000}; n++) begin
         @(negedge core_clk);
      end
      `CHK(axis_o[0].pos, tg[2])
      `CHK(axis_o[0].vel, 32'h0001_0000)
      seg(tg[3]);
      hw(6'h03, a[1]);
      cmd(`DMCI_OP_MOVE, 4'h4, 1'b0, 3'h0, 6'h00);
      `CHK(axis_o[2].pos, a[1])
      cmd(`DMCI_OP_CONTOUR, 4'h1, 1'b1, 3'h1, 6'h00);
      repeat (300) @(negedge core_clk);
      hr(`DMCI_W_RDIDX, q);
      `CHK(q, 32'h3)
      u_host.publish();
      wait_rd(3'h4);
      for (int n = 0; n < 3000 && axis_o[0].pos !== tg[3]; n++) @(negedge core_clk);
      `CHK(axis_o[0].pos, tg[3])
      $display("contour test done");
      cmd(`DMCI_OP_INTEN, 4'h0, 1'b0, 3'h0, 6'h01);
      `CHK(host_irq, 1'b1)
      cmd(`DMCI_OP_INTACK, 4'h0, 1'b0, 3'h0, 6'h01);
      `CHK(host_irq, 1'b0)
      cmd(`DMCI_OP_INTEN, 4'h0, 1'b0, 3'h0, 6'h20);
      `CHK(host_irq, 1'b1)
      cmd(`DMCI_OP_INTEN, 4'h0, 1'b0, 3'h0, 6'h00);
      `CHK(host_irq, 1'b0)
      $display("interrupt test done");
      old[0] = axis_o[0].pos;
      cmd(8'h7E, 4'hF, 1'b0, 3'h0, 6'h00);
      `CHK(axis_o[0].pos, old[0])
      // Stop lands in the middle of a long segment
      cmd(`DMCI_OP_CONTOUR, 4'h1, 1'b0, 3'h3, 6'h00);
      seg(tg[0]);
      u_host.publish();
      wait_rd(3'h5);
      cmd(`DMCI_OP_STOP, 4'hF, 1'b0, 3'h0, 6'h00);
      old[0] = axis_o[0].pos;
      seg(tg[1]);
      u_host.publish();
      repeat (400) @(negedge core_clk);
      `CHK(axis_o[0].pos, old[0])
      hr(`DMCI_W_RDIDX, q);
      `CHK(q, 32'h5)
      `CHK(u_host.n_noack, 0)
      $display("stop test done");
      test_done();
   end
endmodule : dmci_intake_tb
